// ---- rtl/tx_pcs_consts.svh ----
// Constants of the transmit coding path: offsets, fields, codes, timing
`ifndef TX_PCS_CONSTS_SVH
`define TX_PCS_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define OFS_CTRL        4'h0
`define OFS_VOD         4'h4
`define OFS_STATUS      4'h8

// ==========================================================
// Control register fields
`define CTRL_CHAN_EN    0
`define CTRL_PLL_PDN    1
`define CTRL_REF_LO     2
`define CTRL_REF_HI     3
`define CTRL_DIV_LO     4
`define CTRL_DIV_HI     6
`define CTRL_DOUBLE     7
`define CTRL_WIDE10     8
`define CTRL_ENC_BYP    9
`define CTRL_PROTO_LO   10
`define CTRL_PROTO_HI   11
`define CTRL_GIGABIT_ETHERNET_MODE_SM    12
`define CTRL_WIDTH      13
`define CTRL_RESET      13'h1001

// ==========================================================
// Swing register fields
`define VOD_SEL_LO      0
`define VOD_SEL_HI      2
`define VOD_TERM_LO     4
`define VOD_TERM_HI     5
`define VOD_WIDTH       6
`define VOD_RESET       6'h00
`define VOD_MV_RESET    11'h190

// ==========================================================
// Transmit PLL divider values
`define DIV_4           5'h04
`define DIV_8           5'h08
`define DIV_10          5'h0a
`define DIV_16          5'h10
`define DIV_20          5'h14

// ==========================================================
// Code bytes (y in [7:5], x in [4:0])
`define XG_IDLE         8'h07
`define K28_0           8'h1c
`define K28_3           8'h7c
`define K28_5           8'hbc
`define K30_7           8'hfe
`define D5_6            8'hc5
`define D16_2           8'h50
`define D21_5           8'hb5
`define D2_2            8'h42
`define PRBS_SEED       7'h7f
`define ALIGN_MIN       5'h10

// ==========================================================
// Timing
`define CLK_PERIOD_NS   40
`define PLL_LOCK_NS     2000
`define PLL_LOCK_CYC    ((`PLL_LOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- rtl/tx_pcs_pkg.sv ----
// Types shared by the transmit coding path
package tx_pcs_pkg;

    // Protocol mode of the transmit state machine
    typedef enum logic [1:0] {
        PROTO_BASIC = 2'h0,
        PROTO_GIGABIT_ETHERNET_MODE  = 2'h1,
        PROTO_XAUI  = 2'h2
    } proto_t;

    // Idle rewrite state for gigabit_ethernet_mode
    typedef enum logic [1:0] {
        GS_WAIT_K  = 2'b01,
        GS_AFTER_K = 2'b10
    } gigabit_ethernet_mode_state_t;

endpackage

// ---- rtl/phase_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module phase_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             in_ready,
    output var  logic             out_valid,
    output var  logic [WIDTH-1:0] out_data,
    input  wire logic             out_ready,
    output var  logic [3:0]       level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [3:0]       count_reg;
    logic [3:0]       count_next;
    logic             push;
    logic             pop;

    // Handshakes on each side
    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;
    assign count_next = count_reg + {3'h0, push} - {3'h0, pop};

    // Storage and pointers
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= 4'h0;
            in_ready   <= 1'b1;
            out_valid  <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            in_ready  <= (count_next != 4'(DEPTH)); // Registered full flag
            out_valid <= (count_next != 4'h0);
        end
    end

    assign out_data = mem_reg[rd_ptr_reg];
    assign level    = count_reg;

endmodule

`default_nettype wire

// ---- rtl/serial_tx_pcs_path.sv ----
// Transmit coding path: phase FIFO, byte serializer, encoder, idle logic, serializer
//
// How it works
// - Reference input is one clock chosen from dedicated pin, fabric or inter-block line.
// - PLL divider is 4, 8, 10, 16 or 20; fabric clock halves in double width.
// - PLL may be powered down only while no transmit channel is enabled.
// - Lock status output reports whether the PLL has locked to its reference.
// - A four-word phase FIFO always sits in the path, never bypassed.
// - Double width takes 16 or 20 bit words and emits 8 or 10 bit halves.
// - Single width bypasses the byte serializer; words pass straight through.
// - Encoder maps 8 bits plus control to 10 bits, run length five; bypassable.
// - Gigabit idle sets become K28.5 then D5.6, or K28.5 then D16.2.
// - Idle choice leaves disparity negative; configuration sets are never rewritten.
// - The gigabit idle state machine can be disabled even in gigabit mode.
// - XAUI data maps straight; control 07 idle, 9C to K28.4, FB to K27.7.
// - XAUI K28.0 versus K28.5 idle choice comes from a x^7+x^6+1 generator.
// - XAUI inserts K28.3 into idles at random spacing of 16 to 31.
// - Serializer shifts each 8 or 10 bit word out least significant bit first.
// - Output swing chosen statically or at run time from termination dependent set.
`include "tx_pcs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module serial_tx_pcs_path #(
    parameter int PHASE_FIFO_DEPTH = 4,
    parameter int LOCK_CYCLES      = `PLL_LOCK_CYC,
    parameter logic [2:0] VOD_DEFAULT_SEL = 3'h0
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    input  wire logic        tx_valid,
    input  wire logic [19:0] tx_data,
    input  wire logic [1:0]  tx_ctrl,
    output var  logic        tx_ready,
    output var  logic        tx_serial_out,
    output var  logic [1:0]  ref_clk_select,
    output var  logic        pll_power_on,
    output var  logic        pll_locked,
    output var  logic        fabric_clk_out,
    output var  logic [10:0] vod_mv
);
    // ==========================================================
    // Coding tables (abcdei / fghj, a in the most significant bit)
    localparam logic [5:0] T6 [32] = '{
        6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
        6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
    // Swing levels in mV per termination row of six
    localparam logic [10:0] VOD_MV_TBL [18] = '{
        11'h190, 11'h320, 11'h3e8, 11'h4b0, 11'h578, 11'h640,
        11'h1e0, 11'h3c0, 11'h4b0, 11'h5a0, 11'h000, 11'h000,
        11'h258, 11'h4b0, 11'h5dc, 11'h000, 11'h000, 11'h000};
    localparam logic [2:0] VOD_LEVELS [4] = '{3'h6, 3'h4, 3'h3, 3'h0};

    // Encode one byte; returns {ending disparity, code with bit a at bit 0}
    function automatic logic [10:0] enc_10b(input logic [7:0] d, input logic k, input logic rd);
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] s6;
        logic [3:0] s4;
        logic       pos;
        logic       mid;
        logic       alt;
        logic [9:0] c;
        x   = d[4:0];
        y   = d[7:5];
        pos = k ? 1'b0 : rd; // Control codes are built negative, then inverted when the running disparity is positive
        s6  = (k && x == 5'd28) ? 6'h0f : T6[x];
        if (pos && ($countones(s6) != 3 || x == 5'd7)) begin
            s6 = ~s6;
        end
        mid = pos ^ ($countones(s6) != 3);
        alt = k || (mid ? (x == 5'd11 || x == 5'd13 || x == 5'd14)
                        : (x == 5'd17 || x == 5'd18 || x == 5'd20));
        s4  = (y == 3'd7 && alt) ? 4'h7 : T4[y];
        if (mid && ($countones(s4) != 2 || y == 3'd3)) begin
            s4 = ~s4;
        end
        c = {s6, s4};
        if (k && rd) begin
            c = ~c;
        end
        return {rd ^ ($countones(c) != 5), {<<{c}}};
    endfunction

    // ==========================================================
    // Register file
    logic [`CTRL_WIDTH-1:0] ctrl_reg;
    logic [`VOD_WIDTH-1:0]  vod_reg;
    logic                   vod_bad_reg;
    logic [31:0]            wmask;
    logic                   wr_fire;
    logic                   wr_ctrl;
    logic                   wr_vod;
    logic [3:0]             fifo_level;
    logic                   rd_reg;

    tx_pcs_pkg::proto_t     proto;
    logic                   chan_en;
    logic                   double_w;
    logic                   wide10;
    logic                   enc_byp;
    logic                   gigabit_ethernet_mode_sm_en;
    logic [2:0]             div_sel;

    assign wmask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_fire = avs_write && !avs_waitrequest;
    assign wr_ctrl = wr_fire && (avs_address == `OFS_CTRL);
    assign wr_vod  = wr_fire && (avs_address == `OFS_VOD);

    assign chan_en    = ctrl_reg[`CTRL_CHAN_EN];
    assign div_sel    = ctrl_reg[`CTRL_DIV_HI:`CTRL_DIV_LO];
    assign double_w   = ctrl_reg[`CTRL_DOUBLE];
    assign wide10     = ctrl_reg[`CTRL_WIDE10];
    assign enc_byp    = ctrl_reg[`CTRL_ENC_BYP];
    assign proto      = tx_pcs_pkg::proto_t'(ctrl_reg[`CTRL_PROTO_HI:`CTRL_PROTO_LO]);
    assign gigabit_ethernet_mode_sm_en = ctrl_reg[`CTRL_GIGABIT_ETHERNET_MODE_SM];

    // One wait cycle per access; the write lands on the edge that sees waitrequest low
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    `OFS_CTRL:   avs_readdata <= 32'(ctrl_reg);
                    `OFS_VOD:    avs_readdata <= 32'(vod_reg);
                    `OFS_STATUS: avs_readdata <= {24'h000000, rd_reg, fifo_level, vod_bad_reg,
                                                  pll_power_on, pll_locked};
                    default:     avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= (ctrl_reg & ~wmask[`CTRL_WIDTH-1:0]) | (avs_writedata[`CTRL_WIDTH-1:0] & wmask[`CTRL_WIDTH-1:0]);
        end
    end

    // Swing selection, changeable at run time; unavailable level is flagged and ignored
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            vod_reg     <= {2'h0, 1'b0, VOD_DEFAULT_SEL};
            vod_mv      <= VOD_MV_TBL[VOD_DEFAULT_SEL];
            vod_bad_reg <= 1'b0;
        end else if (wr_vod && avs_byteenable[0]) begin
            vod_reg <= {avs_writedata[`VOD_TERM_HI:`VOD_TERM_LO], 1'b0,
                        avs_writedata[`VOD_SEL_HI:`VOD_SEL_LO]};
            if (avs_writedata[`VOD_SEL_HI:`VOD_SEL_LO] < VOD_LEVELS[avs_writedata[`VOD_TERM_HI:`VOD_TERM_LO]]) begin
                vod_mv      <= VOD_MV_TBL[5'(avs_writedata[`VOD_TERM_HI:`VOD_TERM_LO]) * 5'd6
                                          + 5'(avs_writedata[`VOD_SEL_HI:`VOD_SEL_LO])];
                vod_bad_reg <= 1'b0;
            end else begin
                vod_bad_reg <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Transmit PLL model: reference select, power, lock, fabric clock
    logic [4:0]  div_val;
    logic [4:0]  half_period;
    logic [4:0]  slow_cnt_reg;
    logic [15:0] lock_cnt_reg;
    logic        pll_on_next;

    always_comb begin
        case (div_sel)
            3'h1:    div_val = `DIV_8;
            3'h2:    div_val = `DIV_10;
            3'h3:    div_val = `DIV_16;
            3'h4:    div_val = `DIV_20;
            default: div_val = `DIV_4;
        endcase
    end

    assign half_period = double_w ? div_val : (div_val >> 1);
    assign pll_on_next = !(ctrl_reg[`CTRL_PLL_PDN] && !chan_en);

    // Reference select and power state
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ref_clk_select <= 2'h0;
            pll_power_on   <= 1'b1;
        end else begin
            ref_clk_select <= (ctrl_reg[`CTRL_REF_HI:`CTRL_REF_LO] == 2'h3) ? 2'h0
                              : ctrl_reg[`CTRL_REF_HI:`CTRL_REF_LO];
            pll_power_on   <= pll_on_next;
        end
    end

    // Lock restarts after power-up or any reprogramming of the control register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lock_cnt_reg <= 16'h0000;
            pll_locked   <= 1'b0;
        end else if (!pll_on_next || wr_ctrl) begin
            lock_cnt_reg <= 16'h0000;
            pll_locked   <= 1'b0;
        end else if (lock_cnt_reg == 16'(LOCK_CYCLES - 1)) begin
            pll_locked   <= 1'b1;
        end else begin
            lock_cnt_reg <= lock_cnt_reg + 16'h0001;
        end
    end

    // Fabric clock: period of div_val cycles, doubled in double width
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            slow_cnt_reg   <= 5'h00;
            fabric_clk_out <= 1'b0;
        end else if (!pll_locked) begin // Level holds: no runt pulse
            slow_cnt_reg   <= 5'h00;
        end else if (slow_cnt_reg >= half_period - 5'h01) begin
            slow_cnt_reg   <= 5'h00;
            fabric_clk_out <= !fabric_clk_out;
        end else begin
            slow_cnt_reg   <= slow_cnt_reg + 5'h01;
        end
    end

    // ==========================================================
    // Phase compensation FIFO, always in the path
    logic        fifo_valid;
    logic [21:0] fifo_data;
    logic        fifo_pop;

    phase_fifo #(
        .WIDTH (22),
        .DEPTH (PHASE_FIFO_DEPTH)
    ) u_phase_fifo (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .in_valid  (tx_valid),
        .in_data   ({tx_ctrl, tx_data}),
        .in_ready  (tx_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (fifo_pop),
        .level     (fifo_level)
    );

    // ==========================================================
    // Byte serializer and symbol selection
    logic       half_sel_reg;
    logic       load;
    logic [9:0] sym;
    logic       sym_k;

    always_comb begin
        if (!fifo_valid) begin
            sym   = {2'h0, (proto == tx_pcs_pkg::PROTO_XAUI) ? `XG_IDLE : `K28_5};
            sym_k = 1'b1;
        end else if (double_w && half_sel_reg) begin
            sym   = wide10 ? fifo_data[19:10] : {2'h0, fifo_data[15:8]};
            sym_k = fifo_data[21];
        end else begin
            sym   = wide10 ? fifo_data[9:0] : {2'h0, fifo_data[7:0]};
            sym_k = fifo_data[20];
        end
    end

    assign fifo_pop = load && fifo_valid && (!double_w || half_sel_reg);

    // Half select advances only on symbols taken from the FIFO
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            half_sel_reg <= 1'b0;
        end else if (!double_w) begin
            half_sel_reg <= 1'b0;
        end else if (load && fifo_valid) begin
            half_sel_reg <= !half_sel_reg;
        end
    end

    // ==========================================================
    // Transmit state machine: idle mapping per protocol
    tx_pcs_pkg::gigabit_ethernet_mode_state_t gstate_reg;
    logic [6:0]  prbs_reg;
    logic [4:0]  align_cnt_reg;
    logic [7:0]  map_byte;
    logic        xaui_idle;

    assign xaui_idle = (proto == tx_pcs_pkg::PROTO_XAUI) && sym_k && (sym[7:0] == `XG_IDLE);

    always_comb begin
        map_byte = sym[7:0];
        if (proto == tx_pcs_pkg::PROTO_XAUI && sym_k) begin
            case (sym[7:0])
                `XG_IDLE: map_byte = (align_cnt_reg == 5'h00) ? `K28_3
                                     : (prbs_reg[0] ? `K28_5 : `K28_0);
                8'h9c, 8'hfb: map_byte = sym[7:0];
                8'hfd, 8'hfe: map_byte = sym[7:0];
                8'h1c, 8'h3c, 8'h7c, 8'hbc, 8'hdc, 8'hf7: map_byte = sym[7:0];
                default: map_byte = `K30_7;
            endcase
        end else if (proto == tx_pcs_pkg::PROTO_GIGABIT_ETHERNET_MODE && gigabit_ethernet_mode_sm_en && !sym_k
                     && gstate_reg == tx_pcs_pkg::GS_AFTER_K
                     && sym[7:0] != `D21_5 && sym[7:0] != `D2_2) begin
            map_byte = rd_reg ? `D16_2 : `D5_6;
        end
    end

    // Gigabit idle tracking: the byte after K28.5 is the rewrite candidate
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gstate_reg <= tx_pcs_pkg::GS_WAIT_K;
        end else if (load) begin
            case (gstate_reg)
                tx_pcs_pkg::GS_WAIT_K,
                tx_pcs_pkg::GS_AFTER_K: gstate_reg <= (gigabit_ethernet_mode_sm_en && sym_k && sym[7:0] == `K28_5)
                                                      ? tx_pcs_pkg::GS_AFTER_K
                                                      : tx_pcs_pkg::GS_WAIT_K;
                default: gstate_reg <= tx_pcs_pkg::GS_WAIT_K;
            endcase
        end
    end

    // XAUI idle randomizer and alignment spacing
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prbs_reg      <= `PRBS_SEED;
            align_cnt_reg <= `ALIGN_MIN;
        end else if (load && xaui_idle) begin
            prbs_reg <= {prbs_reg[5:0], prbs_reg[6] ^ prbs_reg[5]};
            if (align_cnt_reg == 5'h00) begin
                align_cnt_reg <= `ALIGN_MIN | {1'b0, prbs_reg[3:0]};
            end else begin
                align_cnt_reg <= align_cnt_reg - 5'h01;
            end
        end
    end

    // ==========================================================
    // Encoder and serializer
    logic [10:0] enc;
    logic [9:0]  shift_reg;
    logic [3:0]  bit_cnt_reg;
    logic [3:0]  word_len;

    assign enc      = enc_10b(map_byte, sym_k, rd_reg);
    assign word_len = (enc_byp && !wide10) ? 4'h8 : 4'ha;
    assign load     = pll_locked && chan_en && (bit_cnt_reg == 4'h0);

    // Word shifter; a stopped channel holds the line low
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            shift_reg     <= 10'h000;
            bit_cnt_reg   <= 4'h0;
            rd_reg        <= 1'b0;
            tx_serial_out <= 1'b0;
        end else if (load) begin
            if (enc_byp) begin
                tx_serial_out <= sym[0];
                shift_reg     <= {1'b0, sym[9:1]};
            end else begin
                tx_serial_out <= enc[0];
                shift_reg     <= {1'b0, enc[9:1]};
                rd_reg        <= enc[10];
            end
            bit_cnt_reg <= word_len - 4'h1;
        end else if (bit_cnt_reg != 4'h0) begin
            tx_serial_out <= shift_reg[0];
            shift_reg     <= {1'b0, shift_reg[9:1]};
            bit_cnt_reg   <= bit_cnt_reg - 4'h1;
        end else begin
            tx_serial_out <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- verification/tx_pcs_monitor.sv ----
// Checker on the ports of the transmit coding path
`timescale 1ns/1ps
`default_nettype none
module tx_pcs_monitor (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  ref_clk_select,
    input wire logic        pll_power_on,
    input wire logic        pll_locked,
    input wire logic        fabric_clk_out,
    input wire logic [10:0] vod_mv
);
    // ====
    // Bus handshake, clocking and swing outputs
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest not dropped");
    a_wait_back_high: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_at_rest: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("waitrequest low at rest");
    a_ref_sel_legal: assert property (ref_clk_select != 2'h3)
        else $error("reference select illegal");
    a_lock_needs_power: assert property (!pll_power_on |-> !pll_locked)
        else $error("locked while powered off");
    a_lock_after_wait: assert property ($rose(pll_locked) |-> !$past(pll_locked, 3))
        else $error("lock came too soon");
    a_fabric_half_min: assert property ($changed(fabric_clk_out) |=> $stable(fabric_clk_out))
        else $error("fabric clock half period short");
    a_vod_in_table: assert property (vod_mv inside {11'h190, 11'h320, 11'h3e8, 11'h4b0, 11'h578, 11'h640,
        11'h1e0, 11'h3c0, 11'h5a0, 11'h258, 11'h5dc})
        else $error("swing not in table");
endmodule
bind serial_tx_pcs_path tx_pcs_monitor u_tx_pcs_monitor (.core_clk, .resetn, .avs_read, .avs_write,
    .avs_waitrequest, .ref_clk_select, .pll_power_on, .pll_locked, .fabric_clk_out, .vod_mv);
`default_nettype wire

// ---- verification/fabric_source.sv ----
// Core-side source of parallel words for the transmit path
`timescale 1ns/1ps
`default_nettype none
module fabric_source (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        tx_ready,
    output var  logic        tx_valid = 1'b0,
    output var  logic [19:0] tx_data = 20'h0,
    output var  logic [1:0]  tx_ctrl = 2'h0
);
    logic [21:0] q [$];
    // ====
    // Offer head word on the same clock as the path, hold until taken
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_valid <= 1'b0;
        end else begin
            if (tx_valid && tx_ready)
                q.delete(0);
            tx_valid <= (q.size() != 0);
            {tx_ctrl, tx_data} <= (q.size() != 0) ? q[0] : {tx_ctrl, ~tx_data}; // Idle data lines toggle; control lines hold
        end
    end
    // Queue one word for sending
    task automatic send(input logic [19:0] d, input logic [1:0] c = 2'h0);
        @(negedge core_clk);
        q.push_back({c, d});
    endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Bench for the transmit coding path
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest, tx_valid, tx_ready, tx_serial_out;
    logic        pll_power_on, pll_locked, fabric_clk_out, found;
    logic [19:0] tx_data, sr = 20'h0;
    logic [1:0]  tx_ctrl, ref_clk_select;
    logic [10:0] vod_mv;
    logic [15:0] vtab [5] = '{16'h0190, 16'h2e40, 16'h5da0, 16'h95dc, 16'h65dc};
    int          n_mismatch = 0, checks_done = 0, run = 0, run_max = 0, i, k;
    serial_tx_pcs_path #(.LOCK_CYCLES(4)) u_serial_tx_pcs_path (.core_clk, .resetn, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .tx_valid, .tx_data, .tx_ctrl, .tx_ready, .tx_serial_out, .ref_clk_select, .pll_power_on,
        .pll_locked, .fabric_clk_out, .vod_mv);
    fabric_source u_fabric_source (.core_clk, .resetn, .tx_ready, .tx_valid, .tx_data, .tx_ctrl);
    // ====
    // Clock, serial capture and run length
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        sr <= {tx_serial_out, sr[19:1]};
        run <= (tx_serial_out === sr[19]) ? run + 1 : 1;
        run_max <= (run > run_max) ? run : run_max;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One register access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
        @(posedge core_clk);
        avs_address <= a;
        avs_byteenable <= be;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    // Write control and wait for lock
    task automatic cfg(input logic [31:0] d);
        bus(1'b1, 4'h0, d);
        for (i = 0; i < 20 && pll_locked !== 1'b1; i++) @(negedge core_clk);
    endtask
    // Search the serial stream for either of two patterns
    task automatic look(input logic [19:0] p, input logic [19:0] q, input logic [19:0] m);
        found = 1'b0;
        for (i = 0; i < 900 && !found; i++) begin
            @(negedge core_clk);
            found = ((sr & m) === p) || ((sr & m) === q);
        end
        chk(found, 1'b1);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ====
    // Watchdog
    initial begin
        #800000;
        n_mismatch++;
        test_done();
    end
    // ====
    // Tests
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h1001);
        chk(vod_mv, 11'h190);
        bus(1'b0, 4'hc, 32'h0);
        chk(rd, 32'h0);
        for (k = 0; k < 4; k++) begin
            bus(1'b1, 4'h0, 32'h1001 | (k << 2));
            chk(ref_clk_select, (k == 3) ? 0 : k);
        end
        bus(1'b1, 4'h0, 32'h2);
        chk(pll_power_on, 1'b0);
        chk(pll_locked, 1'b0);
        bus(1'b1, 4'h0, 32'h3);
        chk(pll_power_on, 1'b1);
        cfg(32'h1001);
        chk(pll_locked, 1'b1);
        $display("test clock done");
        for (k = 0; k < 5; k++) begin
            bus(1'b1, 4'h4, {26'h0, vtab[k][15:14], 1'b0, vtab[k][13:11]});
            chk(vod_mv, vtab[k][10:0]);
        end
        bus(1'b1, 4'h4, 32'h0, 4'he);
        chk(vod_mv, 11'h5dc);
        bus(1'b0, 4'h8, 32'h0);
        chk(rd[2], 1'b1);
        $display("test swing done");
        bus(1'b1, 4'h0, 32'h1000);
        for (k = 0; k < 6; k++) u_fabric_source.send(20'h002c9);
        repeat (12) @(negedge core_clk);
        chk(tx_ready, 1'b0);
        bus(1'b0, 4'h8, 32'h0);
        chk(rd[6:3], 4'h4);
        cfg(32'h301);
        look(20'hb2400, 20'hb2400, 20'hffc00);
        chk(tx_ready, 1'b1);
        $display("test fifo done");
        cfg(32'h381);
        u_fabric_source.send(20'hd44a6);
        u_fabric_source.send(20'hd44a6);
        look(20'hd44a6, 20'hd44a6, 20'hfffff);
        $display("test double done");
        cfg(32'h101);
        look(20'h5f000, 20'ha0c00, 20'hffc00);
        run_max = 0;
        repeat (200) @(negedge core_clk);
        chk(run_max > 5, 1'b0);
        $display("test coding done");
        cfg(32'h901);
        look(20'hcf000, 20'h30c00, 20'hffc00);
        look(20'h2f000, 20'hd0c00, 20'hffc00);
        cfg(32'h1401);
        u_fabric_source.send(20'h000bc, 2'h1);
        u_fabric_source.send(20'h0);
        look(20'h69400, 20'ha2400, 20'hffc00);
        $display("test idle done");
        test_done();
    end
endmodule
`default_nettype wire
